// ### rtl/monitor_consts.vh
// Register offsets, field positions, reset values and timing counts
// shared by the monitor sequencer, its serial port and its math engine.
// Assumes inclusion by bare name from files under rtl/.
`ifndef MONITOR_CONSTS_VH
`define MONITOR_CONSTS_VH

// =====================================================================
// Register pointers
`define REG_CONFIG        8'h00
`define REG_SHUNT         8'h01
`define REG_BUS           8'h02
`define REG_POWER         8'h03
`define REG_CURRENT       8'h04
`define REG_CALIB         8'h05

// =====================================================================
// Configuration fields
`define CFG_RESET_VAL     16'h399F
`define CFG_SOFT_RST_BIT  15
`define CFG_BUS_RANGE_SELECT_BIT      13
`define CFG_GAIN_HI       12
`define CFG_GAIN_LO       11
`define CFG_BAVG_HI       10
`define CFG_BAVG_LO       7
`define CFG_SAVG_HI       6
`define CFG_SAVG_LO       3
`define CFG_MODE_HI       2
`define CFG_MODE_LO       0
`define MODE_POWER_DOWN   3'h0
`define MODE_ADC_OFF      3'h4
`define MODE_SHUNT_BIT    0
`define MODE_BUS_BIT      1
`define MODE_CONT_BIT     2
`define CALIB_RESET_VAL   16'h0000
`define CALIB_WR_MASK     16'hFFFE

// =====================================================================
// Math scaling
`define CURRENT_SHIFT     12
`define POWER_DIVISOR     29'h0001388

// =====================================================================
// Serial port and timing
`define SLAVE_ADDR        7'h40
`define CLK_PERIOD_NS     4
`define PD_RECOVERY_NS    40000

`endif

// ### rtl/serial_port.v
// Two-wire serial slave that carries a register pointer and 16-bit
// words, MSB first. Assumes scl_in and sda_in are raw pin levels.
`timescale 1ns/1ns
`include "monitor_consts.vh"

module serial_port (
	input  wire        clock,
	input  wire        sys_rst,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output reg         sda_oe,
	output reg  [7:0]  reg_ptr,
	input  wire [15:0] rd_word,
	output reg         wr_pulse,
	output reg  [15:0] wr_data,
	output reg         rd_pulse
);
	localparam ST_IDLE = 3'd0;
	localparam ST_RX   = 3'd1;
	localparam ST_ACK  = 3'd2;
	localparam ST_TX   = 3'd3;
	localparam ST_TACK = 3'd4;

	// =================================================================
	// Pin synchronisers; stage 1 feeds only stage 2
	reg scl_s1_q, scl_s2_q, scl_s3_q;
	reg sda_s1_q, sda_s2_q, sda_s3_q;
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= 3'b111;
			{sda_s1_q, sda_s2_q, sda_s3_q} <= 3'b111;
		end else begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_in, scl_s1_q, scl_s2_q};
			{sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
		end
	end
	wire scl_rise = scl_s2_q & ~scl_s3_q;
	wire scl_fall = ~scl_s2_q & scl_s3_q;
	wire start_c  = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	wire stop_c   = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
	assign sda_out = 1'b0;

	// =================================================================
	// Byte engine
	reg [2:0] state_q;
	reg [3:0] bitcnt_q;
	reg [7:0] shreg_q;
	reg [1:0] byte_q;
	reg       ack_q;
	reg       rw_q;
	reg       lo_q;
	wire [7:0] rx_byte = {shreg_q[6:0], sda_s2_q};

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q  <= ST_IDLE;
			bitcnt_q <= 4'h0;
			shreg_q  <= 8'h00;
			byte_q   <= 2'd0;
			ack_q    <= 1'b0;
			rw_q     <= 1'b0;
			lo_q     <= 1'b0;
			sda_oe   <= 1'b0;
			reg_ptr  <= 8'h00;
			wr_pulse <= 1'b0;
			wr_data  <= 16'h0000;
			rd_pulse <= 1'b0;
		end else begin
			wr_pulse <= 1'b0;
			rd_pulse <= 1'b0;
			if (start_c) begin
				state_q  <= ST_RX;
				bitcnt_q <= 4'h0;
				byte_q   <= 2'd0;
				sda_oe   <= 1'b0;
			end else if (stop_c) begin
				state_q <= ST_IDLE;
				sda_oe  <= 1'b0;
			end else begin
				case (state_q)
				ST_RX: begin
					if (scl_rise) begin
						shreg_q  <= rx_byte;
						bitcnt_q <= bitcnt_q + 4'h1;
						if (bitcnt_q == 4'h7) begin
							ack_q <= 1'b1;
							case (byte_q)
							2'd0: begin
								ack_q <= (rx_byte[7:1] == `SLAVE_ADDR);
								rw_q  <= rx_byte[0];
								byte_q <= 2'd1;
							end
							2'd1: begin
								reg_ptr <= rx_byte;
								byte_q  <= 2'd2;
							end
							2'd2: begin
								wr_data[15:8] <= rx_byte;
								byte_q <= 2'd3;
							end
							default: begin
								wr_data[7:0] <= rx_byte;
								wr_pulse <= 1'b1;
								byte_q <= 2'd2;
							end
							endcase
						end
					end else if (scl_fall && bitcnt_q == 4'h8) begin
						bitcnt_q <= 4'h0;
						if (ack_q) begin
							sda_oe  <= 1'b1;
							state_q <= ST_ACK;
						end else
							state_q <= ST_IDLE;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rw_q && byte_q == 2'd1) begin
							// Word is captured once; later bytes come from it
							shreg_q  <= rd_word[15:8];
							wr_data  <= rd_word;
							sda_oe   <= ~rd_word[15];
							rd_pulse <= 1'b1;
							lo_q     <= 1'b0;
							state_q  <= ST_TX;
						end else begin
							sda_oe  <= 1'b0;
							state_q <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_rise)
						bitcnt_q <= bitcnt_q + 4'h1;
					else if (scl_fall) begin
						if (bitcnt_q == 4'h8) begin
							bitcnt_q <= 4'h0;
							sda_oe   <= 1'b0;
							state_q  <= ST_TACK;
						end else begin
							shreg_q <= {shreg_q[6:0], 1'b0};
							sda_oe  <= ~shreg_q[6];
						end
					end
				end
				ST_TACK: begin
					if (scl_rise && sda_s2_q)
						state_q <= ST_IDLE;
					else if (scl_fall) begin
						shreg_q <= lo_q ? wr_data[15:8] : wr_data[7:0];
						sda_oe  <= lo_q ? ~wr_data[15] : ~wr_data[7];
						lo_q    <= ~lo_q;
						state_q <= ST_TX;
					end
				end
				default: state_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // serial_port

// ### rtl/result_engine.v
// Background current and power calculation from one latched set of
// shunt, bus and calibration values. Assumes start is a one-cycle pulse.
`timescale 1ns/1ns
`include "monitor_consts.vh"

module result_engine (
	input  wire        clock,
	input  wire        sys_rst,
	input  wire        start,
	input  wire [15:0] shunt,
	input  wire [12:0] bus,
	input  wire [15:0] calib,
	output reg         done,
	output reg  [15:0] current,
	output reg  [15:0] power,
	output reg         overflow
);
	reg        busy_q;
	reg [4:0]  step_q;
	reg [28:0] dividend_q;
	reg [28:0] rem_q;

	wire signed [32:0] prod_i =
		$signed(shunt) * $signed({1'b0, calib});
	wire signed [32:0] cur_w  = prod_i >>> `CURRENT_SHIFT;
	wire [15:0]  cur_abs = current[15] ? (16'h0000 - current) : current;
	wire [28:0]  rem_sh  = {rem_q[27:0], dividend_q[28]};
	wire         fits    = (rem_sh >= `POWER_DIVISOR);

	// =================================================================
	// Multiply, then restoring division by the power divisor
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			busy_q     <= 1'b0;
			step_q     <= 5'd0;
			dividend_q <= 29'h0000000;
			rem_q      <= 29'h0000000;
			done       <= 1'b0;
			current    <= 16'h0000;
			power      <= 16'h0000;
			overflow   <= 1'b0;
		end else begin
			done <= 1'b0;
			// A start while busy is dropped: groups shorter than the
			// divider would otherwise restart it and never let it finish
			if (start && !busy_q) begin
				current  <= cur_w[15:0];
				overflow <= (cur_w[32:15] != {18{cur_w[15]}});
				busy_q   <= 1'b1;
				step_q   <= 5'd0;
				rem_q    <= 29'h0000000;
				dividend_q <= 29'h0000000;
			end else if (busy_q) begin
				if (step_q == 5'd0) begin
					dividend_q <= cur_abs * bus;
					step_q     <= 5'd1;
				end else begin
					rem_q      <= fits ? rem_sh - `POWER_DIVISOR : rem_sh;
					dividend_q <= {dividend_q[27:0], fits};
					step_q     <= step_q + 5'd1;
					if (step_q == 5'd29) begin
						power  <= {dividend_q[14:0], fits};
						busy_q <= 1'b0;
						done   <= 1'b1;
					end
				end
			end
		end
	end
endmodule // result_engine

// ### rtl/monitor_sequencer.v
// Conversion sequencer and register file of a shunt current and power
// monitor. Assumes an ADC on the same clock that answers each conv_req
// with one adc_done pulse, and a host on the two-wire serial pins.
`timescale 1ns/1ns
`include "monitor_consts.vh"

// Notes on behaviour
// - Continuous combined mode repeats shunt-then-bus group pairs of the selected averaging.
// - In combined modes each shunt group is followed by a bus group before the next shunt.
// - Mode codes give shunt-only or bus-only, continuous or triggered.
// - Current and power computed in background; sequencing never waits.
// - Leaving power-down waits the recovery time before converting.
// - ADC-off code stops all conversions until another mode is written.
// - Every write of a triggered code launches one single-shot cycle.
// - Result registers always readable, holding last completed results.
// - Ready flag sets only after conversions, averaging and math finish.
// - Config writes clear the ready flag, except power-down or ADC-off.
// - Reading the bus voltage register clears the ready flag.
// - Shunt and bus resolution and averaging are programmed separately.
// - Shunt gain select scales full scale by one, two, four or eight.
// - A single bus range bit picks the 16 V or 32 V range.
// - All registers take defaults on reset; host must reprogram after.
// - Power LSB is twenty times the current LSB through the scaling.
// - Current equals shunt result times calibration divided by 4096.
// - Power equals current times bus result divided by 5000.
// - Current and power produced only with a programmed calibration.
// - Bus range bit sits at bit 13 of configuration register zero.
module monitor_sequencer #(
	parameter WAKE_CYCLES =
		(`PD_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input  wire        clock,
	input  wire        sys_rst,
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe,
	output reg         conv_req,
	output reg         conv_bus,
	output reg  [1:0]  conv_resolution,
	output reg  [1:0]  shunt_gain_select,
	output reg         bus_range_select,
	output reg         analog_off,
	input  wire        adc_done,
	input  wire [15:0] adc_data
);
	localparam S_IDLE   = 3'd0;
	localparam S_WAKE   = 3'd1;
	localparam S_SREQ   = 3'd2;
	localparam S_SWAIT  = 3'd3;
	localparam S_BREQ   = 3'd4;
	localparam S_BWAIT  = 3'd5;

	// =================================================================
	// Serial port
	wire        port_oe;
	wire        port_out;
	wire [7:0]  reg_ptr;
	wire        wr_pulse;
	wire [15:0] wr_data;
	wire        rd_pulse;
	reg  [15:0] rd_word;

	serial_port u_port (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_out  (port_out),
		.sda_oe   (port_oe),
		.reg_ptr  (reg_ptr),
		.rd_word  (rd_word),
		.wr_pulse (wr_pulse),
		.wr_data  (wr_data),
		.rd_pulse (rd_pulse)
	);

	// =================================================================
	// Registers
	reg  [15:0] config_q;
	reg  [15:0] calib_q;
	reg  [15:0] shunt_q;
	reg  [12:0] bus_q;
	reg  [15:0] current_q;
	reg  [15:0] power_q;
	reg         ready_q;
	reg         ovf_q;

	wire [2:0]  mode     = config_q[`CFG_MODE_HI:`CFG_MODE_LO];
	wire [3:0]  savg     = config_q[`CFG_SAVG_HI:`CFG_SAVG_LO];
	wire [3:0]  bavg     = config_q[`CFG_BAVG_HI:`CFG_BAVG_LO];
	wire [2:0]  wr_mode  = wr_data[`CFG_MODE_HI:`CFG_MODE_LO];
	wire        cfg_wr   = wr_pulse && (reg_ptr == `REG_CONFIG);
	wire        soft_rst = cfg_wr && wr_data[`CFG_SOFT_RST_BIT];
	wire        cal_wr   = wr_pulse && (reg_ptr == `REG_CALIB);

	always @* begin
		case (reg_ptr)
		`REG_CONFIG:  rd_word = config_q;
		`REG_SHUNT:   rd_word = shunt_q;
		`REG_BUS:     rd_word = {bus_q, 1'b0, ready_q, ovf_q};
		`REG_POWER:   rd_word = power_q;
		`REG_CURRENT: rd_word = current_q;
		`REG_CALIB:   rd_word = calib_q;
		default:      rd_word = 16'h0000;
		endcase
	end

	// =================================================================
	// Sequencer
	reg  [2:0]  state_q;
	reg  [13:0] wake_q;
	reg  [7:0]  count_q;
	reg  signed [23:0] acc_q;
	reg         pd_q;
	reg         math_go_q;

	// Averaging code: top bit clear means one sample at chosen resolution
	wire [3:0]  avg      = (state_q == S_BWAIT) ? bavg : savg;
	wire [2:0]  avg_log  = avg[3] ? avg[2:0] : 3'd0;
	wire [7:0]  avg_n    = 8'h01 << avg_log;
	wire signed [23:0] sample = (state_q == S_BWAIT) ?
		{11'h000, adc_data[12:0]} : {{8{adc_data[15]}}, adc_data};
	wire signed [23:0] acc_n  = acc_q + sample;
	wire signed [23:0] avg_v  = acc_n >>> avg_log;
	wire        group_end = adc_done && (count_q == avg_n - 8'h01);
	wire [2:0]  first_grp = mode[`MODE_SHUNT_BIT] ? S_SREQ : S_BREQ;
	wire        active    = mode[`MODE_SHUNT_BIT] | mode[`MODE_BUS_BIT];

	wire        math_done;
	wire [15:0] math_cur;
	wire [15:0] math_pwr;
	wire        math_ovf;

	result_engine u_math (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.start    (math_go_q),
		.shunt    (shunt_q),
		.bus      (bus_q),
		.calib    (calib_q),
		.done     (math_done),
		.current  (math_cur),
		.power    (math_pwr),
		.overflow (math_ovf)
	);

	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			config_q  <= `CFG_RESET_VAL;
			calib_q   <= `CALIB_RESET_VAL;
			shunt_q   <= 16'h0000;
			bus_q     <= 13'h0000;
			current_q <= 16'h0000;
			power_q   <= 16'h0000;
			ready_q   <= 1'b0;
			ovf_q     <= 1'b0;
			state_q   <= S_IDLE;
			wake_q    <= 14'h0000;
			count_q   <= 8'h00;
			acc_q     <= 24'h000000;
			pd_q      <= 1'b0;
			math_go_q <= 1'b0;
			conv_req  <= 1'b0;
			conv_bus  <= 1'b0;
		end else if (soft_rst) begin
			// Soft reset returns every host register to its default; count_q, acc_q and conv_bus keep their values
			config_q  <= `CFG_RESET_VAL;
			calib_q   <= `CALIB_RESET_VAL;
			shunt_q   <= 16'h0000;
			bus_q     <= 13'h0000;
			current_q <= 16'h0000;
			power_q   <= 16'h0000;
			ready_q   <= 1'b0;
			ovf_q     <= 1'b0;
			state_q   <= pd_q ? S_WAKE : S_IDLE;
			wake_q    <= 14'h0000;
			pd_q      <= 1'b0;
			math_go_q <= 1'b0;
			conv_req  <= 1'b0;
		end else begin
			math_go_q <= 1'b0;
			conv_req  <= 1'b0;
			if (cal_wr)
				calib_q <= wr_data & `CALIB_WR_MASK;

			// Math completion wins over a bus-read or config-write clear in the same cycle, but not over soft reset
			if (math_done) begin
				ready_q   <= 1'b1;
				ovf_q     <= math_ovf;
				current_q <= (calib_q == 16'h0000) ?
					16'h0000 : math_cur;
				power_q   <= (calib_q == 16'h0000) ?
					16'h0000 : math_pwr;
			end else if (rd_pulse && reg_ptr == `REG_BUS)
				ready_q <= 1'b0;
			else if (cfg_wr && wr_mode != `MODE_POWER_DOWN &&
					wr_mode != `MODE_ADC_OFF)
				ready_q <= 1'b0;

			if (cfg_wr) begin
				// Any config write aborts the running group; power-down and ADC-off codes then idle, others redispatch
				config_q <= wr_data;
				count_q  <= 8'h00;
				acc_q    <= 24'h000000;
				if (wr_mode == `MODE_POWER_DOWN) begin
					pd_q    <= 1'b1;
					state_q <= S_IDLE;
				end else if (pd_q) begin
					pd_q    <= 1'b0;
					wake_q  <= 14'h0000;
					state_q <= S_WAKE;
				end else if (wr_mode == `MODE_ADC_OFF)
					state_q <= S_IDLE;
				else
					state_q <= wr_mode[`MODE_SHUNT_BIT] ?
						S_SREQ : S_BREQ;
			end else begin
				case (state_q)
				S_IDLE: begin
					if (mode[`MODE_CONT_BIT] && active)
						state_q <= first_grp;
				end
				S_WAKE: begin
					if (wake_q == WAKE_CYCLES - 1) begin
						state_q <= active ? first_grp : S_IDLE;
					end else
						wake_q <= wake_q + 14'h0001;
				end
				S_SREQ, S_BREQ: begin
					conv_req <= 1'b1;
					conv_bus <= (state_q == S_BREQ);
					state_q  <= (state_q == S_BREQ) ? S_BWAIT : S_SWAIT;
				end
				S_SWAIT: begin
					if (adc_done) begin
						acc_q   <= acc_n;
						count_q <= count_q + 8'h01;
						if (!group_end)
							state_q <= S_SREQ;
						else begin
							shunt_q <= avg_v[15:0];
							count_q <= 8'h00;
							acc_q   <= 24'h000000;
							if (mode[`MODE_BUS_BIT])
								state_q <= S_BREQ;
							else begin
								math_go_q <= 1'b1;
								state_q <= mode[`MODE_CONT_BIT] ?
									S_SREQ : S_IDLE;
							end
						end
					end
				end
				S_BWAIT: begin
					if (adc_done) begin
						acc_q   <= acc_n;
						count_q <= count_q + 8'h01;
						if (!group_end)
							state_q <= S_BREQ;
						else begin
							bus_q     <= avg_v[12:0];
							count_q   <= 8'h00;
							acc_q     <= 24'h000000;
							math_go_q <= 1'b1;
							state_q   <= mode[`MODE_CONT_BIT] ?
								first_grp : S_IDLE;
						end
					end
				end
				default: state_q <= S_IDLE;
				endcase
			end
		end
	end

	// =================================================================
	// Serial pin and analog control outputs, all registered
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sda_out           <= 1'b0;
			sda_oe            <= 1'b0;
			conv_resolution   <= 2'b11;
			shunt_gain_select <= 2'b11;
			bus_range_select  <= 1'b1;
			analog_off        <= 1'b0;
		end else begin
			sda_out <= port_out;
			sda_oe  <= port_oe;
			// Resolution follows the bus code in S_BWAIT, else the shunt code
			conv_resolution <= avg[3] ? 2'b11 : avg[1:0];
			shunt_gain_select <=
				config_q[`CFG_GAIN_HI:`CFG_GAIN_LO];
			bus_range_select  <= config_q[`CFG_BUS_RANGE_SELECT_BIT];
			analog_off <= pd_q;
		end
	end
endmodule // monitor_sequencer

// ### tb/monitor_props.sv
// Concurrent checks on the monitor sequencer's ports.
// Assumes one clock domain; attached by the bind after the module.
`timescale 1ns/1ns
module monitor_props #(
	parameter WAKE_CYCLES = 20
) (
	input wire        clock,
	input wire        sys_rst,
	input wire        scl_in,
	input wire        sda_in,
	input wire        sda_out,
	input wire        sda_oe,
	input wire        conv_req,
	input wire        conv_bus,
	input wire [1:0]  conv_resolution,
	input wire [1:0]  shunt_gain_select,
	input wire        bus_range_select,
	input wire        analog_off,
	input wire        adc_done,
	input wire [15:0] adc_data
);
	// =================================================================
	// Helper logic
	// Cycles since power-down ended; saturates so long runs never wrap
	reg [15:0] wake_q;
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			wake_q <= 16'hFFFF;
		else if (analog_off)
			wake_q <= 16'h0000;
		else if (wake_q != 16'hFFFF)
			wake_q <= wake_q + 16'h0001;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	// =================================================================
	// Properties
	a_req_pulse: assert property (conv_req |=> !conv_req)
		else $error("conversion request longer than one cycle");
	a_first_shunt: assert property (
		$fell(sys_rst) |-> ##[1:4] (conv_req && !conv_bus))
		else $error("no shunt request soon after reset");
	a_chan_hold: assert property ($changed(conv_bus) |-> conv_req)
		else $error("channel changed without a request");
	a_off_idle: assert property (analog_off |-> !conv_req)
		else $error("request while powered down");
	a_wake_wait: assert property (
		conv_req |-> wake_q >= WAKE_CYCLES - 2)
		else $error("request before recovery time elapsed");
	a_reset_vals: assert property ($fell(sys_rst) |->
		bus_range_select && shunt_gain_select == 2'h3 && !analog_off)
		else $error("range or gain not at default after reset");
	a_oe_scl_low: assert property (
		$changed(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("data line changed while serial clock high");
	a_cfg_on_scl: assert property (
		!$stable({shunt_gain_select, bus_range_select}) |->
		scl_in && $past(scl_in, 2))
		else $error("gain or range changed outside a config write");
	c_bus_req: cover property (conv_req && conv_bus);
	c_wake: cover property ($fell(analog_off));
	c_ack: cover property ($rose(sda_oe));
endmodule // monitor_props

bind monitor_sequencer monitor_props #(.WAKE_CYCLES(WAKE_CYCLES)) props (
	.clock(clock), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .conv_req(conv_req),
	.conv_bus(conv_bus), .conv_resolution(conv_resolution),
	.shunt_gain_select(shunt_gain_select),
	.bus_range_select(bus_range_select), .analog_off(analog_off),
	.adc_done(adc_done), .adc_data(adc_data));

// ### tb/serial_host.sv
// Two-wire host model: register writes, pointer-then-read cycles and
// address probes. Assumes the bench resolves the open-drain data line.
`timescale 1ns/1ns
`include "monitor_consts.vh"
module serial_host (
	input  wire clock,
	input  wire sda_line,
	output reg  scl,
	output reg  sda_rel
);
	// Calibration from a 1 mA current step and a 10 milliohm shunt
	localparam [15:0] CAL_VALUE = 40960000 / (1000 * 10);
	integer    i;
	reg [15:0] nak_cnt;
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
		nak_cnt = 16'h0000;
	end
	// =================================================================
	// Bit level; a quarter of 32 ns, moved on falling edges
	task quarter;
		begin
			repeat (8) @(negedge clock);
		end
	endtask
	task put(input logic b);
		begin
			sda_rel = b;
			quarter;
			scl = 1'b1;
			quarter;
			quarter;
			scl = 1'b0;
			quarter;
		end
	endtask
	task get(output logic b);
		begin
			sda_rel = 1'b1;
			quarter;
			scl = 1'b1;
			quarter;
			b = sda_line;
			quarter;
			scl = 1'b0;
			quarter;
		end
	endtask
	task start;
		begin
			sda_rel = 1'b1;
			quarter;
			scl = 1'b1;
			quarter;
			sda_rel = 1'b0;
			quarter;
			scl = 1'b0;
			quarter;
		end
	endtask
	task stop;
		begin
			sda_rel = 1'b0;
			quarter;
			scl = 1'b1;
			quarter;
			sda_rel = 1'b1;
			quarter;
		end
	endtask
	// =================================================================
	// Byte and register level
	task send(input [7:0] v);
		logic b;
		begin
			for (i = 0; i < 8; i = i + 1)
				put(v[7 - i]);
			get(b);
			if (b)
				nak_cnt = nak_cnt + 16'h0001;
		end
	endtask
	task write_reg(input [7:0] p, input [15:0] d);
		begin
			start;
			send({`SLAVE_ADDR, 1'b0});
			send(p);
			send(d[15:8]);
			send(d[7:0]);
			stop;
		end
	endtask
	task read_reg(input [7:0] p, output [15:0] d);
		logic b;
		begin
			start;
			send({`SLAVE_ADDR, 1'b0});
			send(p);
			start;
			send({`SLAVE_ADDR, 1'b1});
			for (i = 0; i < 16; i = i + 1) begin
				get(b);
				d = {d[14:0], b};
				if (i == 7)
					put(1'b0);
			end
			put(1'b1);
			stop;
		end
	endtask
	task probe(input [7:0] a);
		begin
			start;
			send(a);
			stop;
		end
	endtask
endmodule // serial_host

// ### tb/monitor_sequencer_tb.sv
// Self-checking bench: a host model drives the serial pins while a
// small ADC model answers every conversion request after a few cycles.
`timescale 1ns/1ns
`include "monitor_consts.vh"
module monitor_sequencer_tb;
	localparam [15:0] SHUNT_CODE = 16'h0100;
	localparam [12:0] BUS_CODE   = 13'h0BB8;
	localparam [15:0] BUS_RDY    = {BUS_CODE, 3'h2};
	localparam [15:0] BUS_IDLE   = {BUS_CODE, 3'h0};
	localparam [31:0] CUR = 32'h0100 * 32'h1000 / 32'h1000;
	localparam [31:0] PWR = CUR * 32'h0BB8 / 32'd5000;
	reg        clock;
	reg        sys_rst;
	reg        adc_done;
	reg [15:0] adc_data;
	reg [2:0]  wait_n;
	reg        chan;
	reg [7:0]  s_cnt;
	reg [7:0]  b_cnt;
	reg [15:0] rd;
	integer    fails;
	integer    cmp_count;
	wire       scl;
	wire       sda_rel;
	wire       sda_oe;
	wire       conv_req;
	wire       conv_bus;
	wire [1:0] shunt_gain_select;
	wire [1:0] conv_resolution;
	wire       sda_out;
	wire       bus_range_select;
	wire       analog_off;
	wire       sda_line = sda_rel & (sda_out | ~sda_oe);

	monitor_sequencer #(.WAKE_CYCLES(20)) uut (
		.clock(clock), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.conv_req(conv_req), .conv_bus(conv_bus),
		.conv_resolution(conv_resolution),
		.shunt_gain_select(shunt_gain_select),
		.bus_range_select(bus_range_select), .analog_off(analog_off),
		.adc_done(adc_done), .adc_data(adc_data));
	serial_host host (.clock(clock), .sda_line(sda_line), .scl(scl),
		.sda_rel(sda_rel));

	always #2 clock = ~clock;
	// =================================================================
	// ADC model; data toggles outside done so a value sampled one cycle late never matches
	always @(negedge clock) begin
		adc_done <= 1'b0;
		adc_data <= ~adc_data;
		if (conv_req) begin
			wait_n <= 3'h3;
			chan <= conv_bus;
			if (conv_bus && b_cnt != 8'h0F)
				b_cnt <= b_cnt + 8'h01;
			if (!conv_bus && s_cnt != 8'h0F)
				s_cnt <= s_cnt + 8'h01;
		end else if (wait_n != 3'h0) begin
			wait_n <= wait_n - 3'h1;
			if (wait_n == 3'h1) begin
				adc_done <= 1'b1;
				adc_data <= chan ? {3'h0, BUS_CODE} : SHUNT_CODE;
			end
		end
	end
	// =================================================================
	// Checking and sequencing tasks
	task chk(input [15:0] got, input [15:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("unexpected at %0t: got %h expected %h",
					$time, got, exp);
			end
		end
	endtask
	task clear_counts;
		begin
			@(posedge clock);
			s_cnt = 8'h00;
			b_cnt = 8'h00;
		end
	endtask
	// Counts after idle modes start only once the write has landed
	task run(input [15:0] c, input [7:0] s, input [7:0] b,
		input [15:0] e, input [15:0] m);
		begin
			clear_counts;
			host.write_reg(`REG_CONFIG, c);
			if (c[1:0] == 2'h0)
				clear_counts;
			host.read_reg(`REG_BUS, rd);
			chk(rd & m, e);
			chk({8'h00, s_cnt}, {8'h00, s});
			chk({8'h00, b_cnt}, {8'h00, b});
		end
	endtask
	task finish_test;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, fails);
			if (fails == 0 && cmp_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// =================================================================
	// Main sequence
	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		adc_done = 1'b0;
		adc_data = 16'h0000;
		wait_n = 3'h0;
		chan = 1'b0;
		s_cnt = 8'h00;
		b_cnt = 8'h00;
		fails = 0;
		cmp_count = 0;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		host.read_reg(`REG_CONFIG, rd);
		chk(rd, `CFG_RESET_VAL);
		host.read_reg(`REG_CALIB, rd);
		chk(rd, `CALIB_RESET_VAL);
		chk({13'h0000, shunt_gain_select, bus_range_select}, 16'h0007);
		host.write_reg(`REG_CALIB, host.CAL_VALUE | 16'h0001);
		$display("test defaults done");
		run(16'h399C, 8'h00, 8'h00, BUS_RDY, 16'hFFFF);
		run(16'h3999, 8'h01, 8'h00, BUS_RDY, 16'hFFFF);
		run(16'h399A, 8'h00, 8'h01, BUS_RDY, 16'hFFFF);
		run(16'h399B, 8'h01, 8'h01, BUS_RDY, 16'hFFFF);
		run(16'h399B, 8'h01, 8'h01, BUS_RDY, 16'hFFFF);
		run(16'h3D4B, 8'h02, 8'h04, BUS_RDY, 16'hFFFF);
		run(16'h399C, 8'h00, 8'h00, BUS_IDLE, 16'hFFFF);
		run(16'h399D, 8'h0F, 8'h00, BUS_RDY, 16'hFFFF);
		run(16'h399C, 8'h00, 8'h00, BUS_RDY, 16'hFFFF);
		run(16'h399E, 8'h00, 8'h0F, BUS_RDY, 16'hFFFF);
		run(16'h399C, 8'h00, 8'h00, BUS_RDY, 16'hFFFF);
		run(16'h399F, 8'h0F, 8'h0F, BUS_RDY, 16'hFFFF);
		run(16'h399C, 8'h00, 8'h00, BUS_RDY, 16'hFFFF);
		run(16'h3998, 8'h00, 8'h00, BUS_IDLE, 16'hFFFF);
		chk({15'h0000, analog_off}, 16'h0001);
		run(16'h399B, 8'h01, 8'h01, BUS_RDY, 16'hFFFF);
		run(16'h0193, 8'h01, 8'h01, BUS_RDY, 16'hFFFF);
		chk({13'h0000, shunt_gain_select, bus_range_select}, 16'h0000);
		chk({14'h0000, conv_resolution}, 16'h0002);
		$display("test modes done");
		host.read_reg(`REG_CALIB, rd);
		chk(rd, host.CAL_VALUE & `CALIB_WR_MASK);
		host.read_reg(`REG_SHUNT, rd);
		chk(rd, SHUNT_CODE);
		host.read_reg(`REG_CURRENT, rd);
		chk(rd, CUR[15:0]);
		host.read_reg(`REG_POWER, rd);
		chk(rd, PWR[15:0]);
		$display("test results done");
		host.write_reg(`REG_CALIB, 16'h0000);
		run(16'h399B, 8'h01, 8'h01, BUS_RDY, 16'hFFFF);
		host.read_reg(`REG_CURRENT, rd);
		chk(rd, 16'h0000);
		host.read_reg(`REG_POWER, rd);
		chk(rd, 16'h0000);
		$display("test zero calibration done");
		host.write_reg(`REG_CALIB, 16'h2000);
		host.write_reg(`REG_CONFIG, 16'h8000);
		host.read_reg(`REG_CONFIG, rd);
		chk(rd, `CFG_RESET_VAL);
		host.read_reg(`REG_CALIB, rd);
		chk(rd, `CALIB_RESET_VAL);
		$display("test soft reset done");
		host.read_reg(8'h07, rd);
		chk(rd, 16'h0000);
		host.probe(8'h84);
		chk(host.nak_cnt, 16'h0001);
		$display("test addressing done");
		finish_test;
	end

	initial begin
		repeat (90000) @(posedge clock);
		fails = fails + 1;
		finish_test;
	end
endmodule // monitor_sequencer_tb
